/* hw/uart_irq_flags.sv */
`timescale 1ns/1ps
module uart_irq_flags (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Control bits
    input wire logic i_soft_reset_bit,
    input wire logic i_global_irq_enable,
    input wire logic i_err_char_accept_enable,
    input wire logic i_dormant_addr_only,
    input wire logic i_multiproc_mode,
    input wire logic i_break_flag_enable,
    input wire logic [3:0] i_irq_enable_wdata,
    input wire logic i_irq_enable_we,
    // Software flag writes (only zeros clear start and tx complete)
    input wire logic [3:0] i_flag_wdata,
    input wire logic i_flag_we,
    // Vector access
    input wire logic i_vector_rd,
    input wire logic i_vector_wr,
    // Transmit side
    input wire logic i_tx_buf_wr,
    input wire logic [7:0] i_tx_buf_data,
    output logic o_tx_valid,
    input wire logic i_tx_take,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_shift_done,
    input wire logic i_tx_busy,
    // Receive side
    input wire logic i_rx_char_done,
    input wire logic [7:0] i_rx_char,
    input wire logic i_rx_char_error,
    input wire logic i_rx_char_is_addr,
    input wire logic i_rx_break,
    input wire logic i_rx_start_byte,
    input wire logic i_rx_busy,
    input wire logic i_rx_buf_rd,
    output logic [7:0] o_rx_holding_buffer,
    // Status
    output logic [3:0] o_flags,
    output logic [3:0] o_irq_enables,
    output logic o_break_seen,
    output logic [7:0] o_irq_vector_value,
    output logic o_irq,
    output logic o_clock_request
);
    logic [3:0] flag_q;
    logic [3:0] flag_d;
    logic [3:0] en_q;
    logic [7:0] rx_buf_q;
    logic break_q;
    logic clk_req_q;
    logic fifo_ready;
    logic rx_set;
    logic [3:0] pend;
    logic [3:0] top_bit;
    localparam int FLAG_COUNT_L = uart_irq_pkg::FLAG_COUNT;

    // Highest-priority pending bit, lowest index wins
    function automatic logic [3:0] top_of(input logic [3:0] p);
        logic [3:0] r;
        r = 4'h0;
        for (int i = FLAG_COUNT_L - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = 4'h0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // Transmit holding buffer in front of the shifter
    uart_char_fifo #(
        .WIDTH(uart_irq_pkg::DATA_WIDTH),
        .DEPTH(uart_irq_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clock(i_clock),
        .i_rst(i_rst || i_soft_reset_bit),
        .i_valid(i_tx_buf_wr),
        .o_ready(fifo_ready),
        .i_data(i_tx_buf_data),
        .o_valid(o_tx_valid),
        .i_ready(i_tx_take),
        .o_data(o_tx_data)
    );

    // Receive qualification
    assign rx_set = (i_rx_char_done
                     && (i_err_char_accept_enable || !i_rx_char_error)
                     && (!i_dormant_addr_only
                         || (i_multiproc_mode && i_rx_char_is_addr)))
                    || (i_rx_break && i_break_flag_enable);

    // Pending enabled flags and top one
    assign pend = flag_q & en_q;
    assign top_bit = top_of(pend);

    // Next flag values; sets win over clears except on the tx ready flag, where clears win
    always_comb begin
        flag_d = flag_q;
        if (i_flag_we) begin
            flag_d[uart_irq_pkg::FLAG_START] = flag_q[uart_irq_pkg::FLAG_START]
                & i_flag_wdata[uart_irq_pkg::FLAG_START];
            flag_d[uart_irq_pkg::FLAG_TXCPT] = flag_q[uart_irq_pkg::FLAG_TXCPT]
                & i_flag_wdata[uart_irq_pkg::FLAG_TXCPT];
        end
        if (i_vector_wr) begin
            flag_d = flag_d & ~pend;
        end else if (i_vector_rd) begin
            flag_d = flag_d & ~top_bit;
        end
        if (i_rx_buf_rd) begin
            flag_d[uart_irq_pkg::FLAG_RX] = 1'b0;
        end
        if (i_tx_buf_wr || !fifo_ready) begin
            flag_d[uart_irq_pkg::FLAG_TX] = 1'b0;
        end else if (!flag_q[uart_irq_pkg::FLAG_TX] && !i_vector_rd && !i_vector_wr) begin
            flag_d[uart_irq_pkg::FLAG_TX] = 1'b1;
        end
        if (rx_set) begin
            flag_d[uart_irq_pkg::FLAG_RX] = 1'b1;
        end
        if (i_rx_start_byte) begin
            flag_d[uart_irq_pkg::FLAG_START] = 1'b1;
        end
        if (i_tx_shift_done) begin
            flag_d[uart_irq_pkg::FLAG_TXCPT] = 1'b1;
        end
    end

    // Flag register
    always_ff @(posedge i_clock) begin
        if (i_rst || i_soft_reset_bit) begin
            flag_q <= uart_irq_pkg::FLAG_RESET;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Enable register
    always_ff @(posedge i_clock) begin
        if (i_rst || i_soft_reset_bit) begin
            en_q <= uart_irq_pkg::ENABLE_RESET;
        end else if (i_irq_enable_we) begin
            en_q <= i_irq_enable_wdata;
        end
    end

    // Receive holding buffer and break status
    always_ff @(posedge i_clock) begin
        if (i_rst || i_soft_reset_bit) begin
            rx_buf_q <= 8'h00;
            break_q <= 1'b0;
        end else begin
            if (i_rx_char_done) begin
                rx_buf_q <= i_rx_char;
            end
            if (i_rx_break && i_break_flag_enable) begin
                break_q <= 1'b1;
            end else if (i_rx_buf_rd) begin
                break_q <= 1'b0;
            end
        end
    end

    // Clock request follows port activity
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            clk_req_q <= 1'b0;
        end else begin
            clk_req_q <= i_tx_busy || i_rx_busy || o_tx_valid;
        end
    end

    // Vector encode
    always_comb begin
        o_irq_vector_value = uart_irq_pkg::VEC_NONE;
        unique case (1'b1)
            top_bit[uart_irq_pkg::FLAG_RX]: o_irq_vector_value = uart_irq_pkg::VEC_RX;
            top_bit[uart_irq_pkg::FLAG_TX]: o_irq_vector_value = uart_irq_pkg::VEC_TX;
            top_bit[uart_irq_pkg::FLAG_START]: o_irq_vector_value = uart_irq_pkg::VEC_START;
            top_bit[uart_irq_pkg::FLAG_TXCPT]: o_irq_vector_value = uart_irq_pkg::VEC_TXCPT;
            default: o_irq_vector_value = uart_irq_pkg::VEC_NONE;
        endcase
    end

    // Outputs
    assign o_irq = (|pend) && i_global_irq_enable;
    assign o_flags = flag_q;
    assign o_irq_enables = en_q;
    assign o_break_seen = break_q;
    assign o_rx_holding_buffer = rx_buf_q;
    assign o_clock_request = clk_req_q;

    // Checks
    irq_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
        o_irq == ((|(flag_q & en_q)) && i_global_irq_enable))
        else $error("irq not gated by enables");
    tx_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_tx_buf_wr && !i_soft_reset_bit |=> !flag_q[1])
        else $error("tx ready not cleared by write");
    rx_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
        rx_set && !i_soft_reset_bit |=> flag_q[0])
        else $error("rx flag not set");
    rx_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rx_buf_rd && !rx_set && !i_soft_reset_bit |=> !flag_q[0])
        else $error("rx flag not cleared by read");
    err_drop_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rx_char_done && i_rx_char_error && !i_err_char_accept_enable
        && !(i_rx_break && i_break_flag_enable) && !flag_q[0] |=> !flag_q[0])
        else $error("error char set rx flag");
    soft_reset_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_soft_reset_bit |=> flag_q[1] && !flag_q[0] && en_q == 4'h0)
        else $error("soft reset values wrong");
    vec_rx_a: assert property (@(posedge i_clock) disable iff (i_rst)
        flag_q[0] && en_q[0] |-> o_irq_vector_value == 8'h02)
        else $error("rx vector not top");
    vec_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_vector_wr && !i_soft_reset_bit && !rx_set && !i_rx_start_byte
        && !i_tx_shift_done |=> (flag_q & $past(en_q) & 4'hd) == 4'h0)
        else $error("vector write left flags");
    clk_req_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_tx_busy || i_rx_busy) |=> o_clock_request)
        else $error("clock not requested while busy");
    clk_drop_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_tx_busy && !i_rx_busy && !o_tx_valid |=> !o_clock_request)
        else $error("clock request held while idle");
    cpt_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_tx_shift_done && !i_soft_reset_bit |=> flag_q[3])
        else $error("tx complete not set");

    // Position shorthands for the checks below
    localparam int RX_B = uart_irq_pkg::FLAG_RX;
    localparam int TX_B = uart_irq_pkg::FLAG_TX;
    localparam int ST_B = uart_irq_pkg::FLAG_START;
    localparam int CP_B = uart_irq_pkg::FLAG_TXCPT;

    // Reset values from either reset source
    por_flags_a: assert property (@(posedge i_clock)
        i_rst |=> flag_q == uart_irq_pkg::FLAG_RESET)
        else $error("flags wrong after reset");
    por_enables_a: assert property (@(posedge i_clock)
        i_rst |=> en_q == uart_irq_pkg::ENABLE_RESET)
        else $error("enables wrong after reset");
    soft_flags_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_soft_reset_bit |=> flag_q == uart_irq_pkg::FLAG_RESET)
        else $error("flags wrong in soft reset");
    soft_fifo_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_soft_reset_bit |=> !o_tx_valid)
        else $error("queue kept data in soft reset");

    // Transmit ready flag, its request and the enable register load
    tx_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
        fifo_ready && !i_tx_buf_wr && !i_vector_rd && !i_vector_wr
        && !i_soft_reset_bit |=> flag_q[TX_B])
        else $error("tx ready not set with room");
    tx_full_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !fifo_ready && !i_soft_reset_bit |=> !flag_q[TX_B])
        else $error("tx ready set while full");
    tx_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
        pend[TX_B] && i_global_irq_enable |-> o_irq)
        else $error("tx ready raised no request");
    tx_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_tx_buf_wr && !i_soft_reset_bit |=> !pend[TX_B])
        else $error("tx ready pending after write");
    en_load_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_irq_enable_we && !i_soft_reset_bit |=> en_q == $past(i_irq_enable_wdata))
        else $error("enables not loaded");

    // Receive flag, buffer and request
    rx_irq_a: assert property (@(posedge i_clock) disable iff (i_rst)
        pend[RX_B] && i_global_irq_enable |-> o_irq)
        else $error("rx flag raised no request");
    rx_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
        flag_q[RX_B] && !i_rx_buf_rd && !i_vector_rd && !i_vector_wr
        && !i_soft_reset_bit |=> flag_q[RX_B])
        else $error("rx flag lost");
    rx_load_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rx_char_done && !i_soft_reset_bit |=> rx_buf_q == $past(i_rx_char))
        else $error("rx buffer not loaded");

    // Receive filtering
    err_accept_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rx_char_done && i_rx_char_error && i_err_char_accept_enable
        && !i_dormant_addr_only && !i_soft_reset_bit |=> flag_q[RX_B])
        else $error("accepted error char dropped");
    dorm_plain_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_dormant_addr_only && !i_multiproc_mode && !(i_rx_break && i_break_flag_enable)
        && !flag_q[RX_B] |=> !flag_q[RX_B])
        else $error("dormant plain mode set rx flag");
    dorm_data_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_dormant_addr_only && i_multiproc_mode && !i_rx_char_is_addr
        && !(i_rx_break && i_break_flag_enable) && !flag_q[RX_B] |=> !flag_q[RX_B])
        else $error("dormant data char set rx flag");
    brk_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rx_break && i_break_flag_enable && !i_soft_reset_bit |=> break_q && flag_q[RX_B])
        else $error("break not flagged");
    brk_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rx_break && !i_break_flag_enable && !i_rx_char_done
        && !flag_q[RX_B] |=> !flag_q[RX_B])
        else $error("disabled break set rx flag");
    brk_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rx_buf_rd && !(i_rx_break && i_break_flag_enable) |=> !break_q)
        else $error("break status not cleared");

    // Start byte and transmit complete flags
    stt_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rx_start_byte && !i_soft_reset_bit |=> flag_q[ST_B])
        else $error("start flag not set");
    stt_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_flag_we && !i_flag_wdata[ST_B] && !i_rx_start_byte |=> !flag_q[ST_B])
        else $error("start flag not cleared");
    stt_keep_a: assert property (@(posedge i_clock) disable iff (i_rst)
        flag_q[ST_B] && !i_flag_we && !i_vector_rd && !i_vector_wr
        && !i_soft_reset_bit |=> flag_q[ST_B])
        else $error("start flag lost");
    cpt_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_flag_we && !i_flag_wdata[CP_B] && !i_tx_shift_done |=> !flag_q[CP_B])
        else $error("tx complete not cleared");
    cpt_keep_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !flag_q[CP_B] && !i_tx_shift_done |=> !flag_q[CP_B])
        else $error("tx complete set without stop bit");

    // Vector priority and access
    vec_tx_a: assert property (@(posedge i_clock) disable iff (i_rst)
        pend[TX_B] && !pend[RX_B] |-> o_irq_vector_value == uart_irq_pkg::VEC_TX)
        else $error("tx vector wrong");
    vec_start_a: assert property (@(posedge i_clock) disable iff (i_rst)
        pend[ST_B] && !pend[RX_B] && !pend[TX_B]
        |-> o_irq_vector_value == uart_irq_pkg::VEC_START)
        else $error("start vector wrong");
    vec_cpt_a: assert property (@(posedge i_clock) disable iff (i_rst)
        pend[CP_B] && !pend[RX_B] && !pend[TX_B] && !pend[ST_B]
        |-> o_irq_vector_value == uart_irq_pkg::VEC_TXCPT)
        else $error("tx complete vector wrong");
    vec_none_a: assert property (@(posedge i_clock) disable iff (i_rst)
        pend == 4'h0 |-> o_irq_vector_value == uart_irq_pkg::VEC_NONE)
        else $error("vector not zero when idle");
    vec_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_vector_rd && !i_vector_wr && top_bit[RX_B] && !rx_set
        && !i_soft_reset_bit |=> !flag_q[RX_B])
        else $error("vector read left top flag");

    // Shared request and clock request
    irq_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_global_irq_enable |-> !o_irq)
        else $error("request without global enable");
    irq_vec_a: assert property (@(posedge i_clock) disable iff (i_rst)
        o_irq |-> o_irq_vector_value != uart_irq_pkg::VEC_NONE)
        else $error("request with empty vector");
    clk_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
        o_tx_valid |=> o_clock_request)
        else $error("clock dropped with queued data");

endmodule // uart_irq_flags

/* shared/uart_irq_pkg.sv */
package uart_irq_pkg;
    // Vector codes
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] VEC_RX = 8'h02;
    localparam logic [7:0] VEC_TX = 8'h04;
    localparam logic [7:0] VEC_START = 8'h06;
    localparam logic [7:0] VEC_TXCPT = 8'h08;
    // Flag positions
    localparam int FLAG_RX = 0;
    localparam int FLAG_TX = 1;
    localparam int FLAG_START = 2;
    localparam int FLAG_TXCPT = 3;
    localparam int FLAG_COUNT = 4;
    // Reset values of flags and enables
    localparam logic [3:0] FLAG_RESET = 4'h2;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    // Example divider settings for 16 MHz at 9600 baud
    localparam logic [15:0] EX_PRESCALE_DIVIDER = 16'h0068;
    localparam logic [3:0] EX_FIRST_MOD_STAGE = 4'h2;
    localparam logic [7:0] EX_SECOND_MOD_STAGE = 8'hd6;
    // FIFO shape
    localparam int FIFO_DEPTH = 8;
    localparam int DATA_WIDTH = 8;
endpackage

/* hw/uart_char_fifo.sv */
`timescale 1ns/1ps
module uart_char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes
    assign o_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem_q[rd_q];

    // Storage
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

    // Pointers and count
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // uart_char_fifo

/* test/uart_remote_station.sv */
`timescale 1ns/1ps
module uart_remote_station (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Character stream from the port
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_stall,
    output logic o_tx_take,
    // Shifter state seen by the port
    output logic o_shift_done,
    output logic o_tx_busy,
    output logic [7:0] o_last_char
);
    logic [2:0] cnt_q;
    // Take a character only while idle and not held off
    assign o_tx_take = i_tx_valid && !i_stall && !o_tx_busy;
    // Shift a few cycles, then report the stop bit gone
    always_ff @(posedge i_clock) begin
        o_shift_done <= 1'b0;
        if (i_rst) begin
            o_tx_busy <= 1'b0;
            cnt_q <= 3'h0;
            o_last_char <= 8'h00;
        end else if (o_tx_take) begin
            o_tx_busy <= 1'b1;
            cnt_q <= 3'h3;
            o_last_char <= i_tx_data;
        end else if (o_tx_busy) begin
            cnt_q <= cnt_q - 3'h1;
            if (cnt_q == 3'h0) begin
                o_tx_busy <= 1'b0;
                o_shift_done <= 1'b1;
            end
        end
    end
endmodule // uart_remote_station

/* test/uart_irq_flags_tb.sv */
`timescale 1ns/1ps
module uart_irq_flags_tb;
    // Pulses: ie_we fl_we vrd vwr txwr rxdone brk stt rxrd (bit 0 up)
    logic [8:0] p = 9'h000;
    // Levels: swr gie eacc dorm mp brken err addr rxbusy stall (bit 0 up)
    logic [9:0] lvl = 10'h000;
    logic [7:0] dat = 8'h00;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic take, sdone, tbusy, tx_valid, brk_seen, irq, creq;
    logic [7:0] tx_data, rx_buf, vec, last;
    logic [3:0] flags, ens;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    // Clock
    always #10 i_clock = ~i_clock;
    uart_irq_flags dut (.i_clock(i_clock), .i_rst(i_rst), .i_soft_reset_bit(lvl[0]),
        .i_global_irq_enable(lvl[1]), .i_err_char_accept_enable(lvl[2]),
        .i_dormant_addr_only(lvl[3]), .i_multiproc_mode(lvl[4]),
        .i_break_flag_enable(lvl[5]), .i_irq_enable_wdata(dat[3:0]), .i_irq_enable_we(p[0]),
        .i_flag_wdata(dat[3:0]), .i_flag_we(p[1]), .i_vector_rd(p[2]), .i_vector_wr(p[3]),
        .i_tx_buf_wr(p[4]), .i_tx_buf_data(dat), .o_tx_valid(tx_valid), .i_tx_take(take),
        .o_tx_data(tx_data), .i_tx_shift_done(sdone), .i_tx_busy(tbusy),
        .i_rx_char_done(p[5]), .i_rx_char(dat), .i_rx_char_error(lvl[6]),
        .i_rx_char_is_addr(lvl[7]), .i_rx_break(p[6]), .i_rx_start_byte(p[7]),
        .i_rx_busy(lvl[8]), .i_rx_buf_rd(p[8]), .o_rx_holding_buffer(rx_buf), .o_flags(flags),
        .o_irq_enables(ens), .o_break_seen(brk_seen), .o_irq_vector_value(vec), .o_irq(irq),
        .o_clock_request(creq));
    uart_remote_station station (.i_clock(i_clock), .i_rst(i_rst), .i_tx_valid(tx_valid),
        .i_tx_data(tx_data), .i_stall(lvl[9]), .o_tx_take(take), .o_shift_done(sdone),
        .o_tx_busy(tbusy), .o_last_char(last));
    task automatic cyc;
        @(posedge i_clock);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One-cycle pulse with data and new levels, then settle
    task automatic pulse(input logic [8:0] m, input logic [7:0] d, input logic [9:0] l);
        cyc;
        p <= m;
        dat <= d;
        lvl <= l;
        cyc;
        p <= 9'h000;
        #1;
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Cut a hang short
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            complete_run;
        end
    end
    initial begin
        repeat (2) cyc;
        i_rst <= 1'b0;
        #1;
        chk({4'h0, flags}, 8'h02);
        chk({4'h0, ens}, 8'h00);
        pulse(9'h001, 8'h00, 10'h002);
        chk(vec, uart_irq_pkg::VEC_NONE);
        chk({7'h0, irq}, 8'h00);
        pulse(9'h001, 8'h02, 10'h002);
        chk(vec, uart_irq_pkg::VEC_TX);
        chk({7'h0, irq}, 8'h01);
        pulse(9'h000, 8'h00, 10'h000);
        chk({7'h0, irq}, 8'h00);
        pulse(9'h001, 8'h0f, 10'h002);
        pulse(9'h020, 8'h5a, 10'h002);
        chk(vec, uart_irq_pkg::VEC_RX);
        chk(rx_buf, 8'h5a);
        chk({7'h0, irq}, 8'h01);
        pulse(9'h100, 8'h00, 10'h002);
        chk({7'h0, flags[0]}, 8'h00);
        pulse(9'h020, 8'h11, 10'h042);
        chk({7'h0, flags[0]}, 8'h00);
        pulse(9'h020, 8'h22, 10'h046);
        chk({7'h0, flags[0]}, 8'h01);
        pulse(9'h100, 8'h00, 10'h01a);
        pulse(9'h020, 8'h33, 10'h01a);
        chk({7'h0, flags[0]}, 8'h00);
        pulse(9'h020, 8'h9a, 10'h09a);
        chk({7'h0, flags[0]}, 8'h01);
        pulse(9'h100, 8'h00, 10'h08a);
        pulse(9'h020, 8'h8a, 10'h08a);
        chk({7'h0, flags[0]}, 8'h00);
        pulse(9'h040, 8'h00, 10'h022);
        chk({7'h0, brk_seen}, 8'h01);
        chk({7'h0, flags[0]}, 8'h01);
        pulse(9'h180, 8'h00, 10'h002);
        chk({7'h0, flags[2]}, 8'h01);
        pulse(9'h002, 8'h0b, 10'h002);
        chk({7'h0, flags[2]}, 8'h00);
        // Fill the queue while the far side stalls
        pulse(9'h000, 8'h00, 10'h202);
        cyc;
        p <= 9'h010;
        for (int i = 0; i < 8; i++) begin
            dat <= 8'(i);
            cyc;
        end
        p <= 9'h000;
        #1;
        chk({7'h0, flags[1]}, 8'h00);
        chk({7'h0, flags[3]}, 8'h00);
        chk({7'h0, creq}, 8'h01);
        pulse(9'h000, 8'h00, 10'h002);
        for (int k = 0; k < 200 && creq !== 1'b0; k++) begin
            cyc;
            #1;
        end
        chk({7'h0, creq}, 8'h00);
        chk(last, 8'h07);
        chk({4'h0, flags}, 8'h0a);
        pulse(9'h020, 8'h44, 10'h002);
        chk(vec, uart_irq_pkg::VEC_RX);
        pulse(9'h004, 8'h00, 10'h002);
        chk(vec, uart_irq_pkg::VEC_TX);
        pulse(9'h008, 8'h00, 10'h002);
        chk({7'h0, flags[3]}, 8'h00);
        cyc;
        #1;
        chk({7'h0, irq}, 8'h01);
        pulse(9'h000, 8'h00, 10'h102);
        chk({7'h0, creq}, 8'h01);
        pulse(9'h000, 8'h00, 10'h002);
        chk({7'h0, creq}, 8'h00);
        pulse(9'h000, 8'h00, 10'h001);
        chk({4'h0, flags}, 8'h02);
        chk({4'h0, ens}, 8'h00);
        chk(uart_irq_pkg::EX_PRESCALE_DIVIDER[7:0], 8'h68);
        chk(uart_irq_pkg::EX_SECOND_MOD_STAGE, 8'hd6);
        complete_run;
    end
endmodule // uart_irq_flags_tb
